// ==== sdc_pkg.sv ====
package sdc_pkg;

   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int          FRAME_BYTES = 16;
   localparam int          FRAME_BITS  = 8 * FRAME_BYTES;
   localparam logic [3:0]  LAST_IDX    = 4'hf;
   localparam int          F_CMD0      = 127;
   localparam int          F_CMD1      = 119;
   localparam int          F_ADDR      = 111;
   localparam int          F_SIZE      = 79;
   localparam int          F_CNT       = 71;
   localparam int          F_DATA      = 39;
   localparam int          F_KIND      = 7;

   // ----------------------------------------------------------------
   // command, size and file kind codes
   // ----------------------------------------------------------------
   localparam logic [7:0]  CMD_WRITE_MEM  = 8'h02;
   localparam logic [7:0]  CMD_WRITE_FILE = 8'h04;
   localparam logic [7:0]  CMD_REENUM     = 8'h06;
   localparam logic [7:0]  SIZE_BYTE      = 8'h08;
   localparam logic [7:0]  SIZE_HALF      = 8'h10;
   localparam logic [7:0]  SIZE_WORD      = 8'h20;
   localparam logic [1:0]  ACC_BYTE       = 2'h0;
   localparam logic [1:0]  ACC_HALF       = 2'h1;
   localparam logic [1:0]  ACC_WORD       = 2'h2;
   localparam logic [7:0]  KIND_APP       = 8'haa;
   localparam logic [7:0]  KIND_SIG       = 8'hcc;
   localparam logic [7:0]  KIND_CFG       = 8'hee;

   // ----------------------------------------------------------------
   // response words and response byte counts
   // ----------------------------------------------------------------
   localparam logic [31:0] ACK_PROD       = 32'h12343412;
   localparam logic [31:0] ACK_OPEN       = 32'h56787856;
   localparam logic [31:0] WR_DONE        = 32'h128a8a12;
   localparam logic [31:0] ST_OK          = 32'hf0f0f0f0;
   localparam logic [31:0] ST_AUTH_FAIL   = 32'h33333333;
   localparam logic [4:0]  TX_WORD        = 5'h04;
   localparam logic [4:0]  TX_TWO_WORDS   = 5'h08;
   localparam logic [4:0]  TX_FOUR_WORDS  = 5'h10;

   // ----------------------------------------------------------------
   // permitted configuration-data windows under production security
   // ----------------------------------------------------------------
   localparam int              N_RANGE  = 2;
   localparam logic [1:0][31:0] RANGE_LO = {32'h20000000, 32'h10000000};
   localparam logic [1:0][31:0] RANGE_HI = {32'h2000ffff, 32'h1000ffff};

   typedef enum logic [2:0] {
      SDC_RECV, SDC_EXEC, SDC_RESP, SDC_STREAM, SDC_AUTH, SDC_RUN
   } sdc_state_t;

endpackage : sdc_pkg

// ==== sdc_range_chk.sv ====
`timescale 1ns/100ps
module sdc_range_chk #(
   parameter int NR = sdc_pkg::N_RANGE
) (
   // span to check
   input  wire logic [31:0] first_i,
   input  wire logic [31:0] last_i,
   // result
   output logic             ok_o
);
   import sdc_pkg::*;

   logic [NR-1:0] hit;

   if (NR < 1 || NR > N_RANGE) begin : g_bad_nr
      $error("sdc_range_chk: bad NR");
   end

   // a span passes only when it sits inside one window whole
   for (genvar g = 0; g < NR; g++) begin : g_win
      assign hit[g] = (first_i >= RANGE_LO[g]) && (last_i <= RANGE_HI[g])
                      && (first_i <= last_i);
   end

   assign ok_o = |hit;

endmodule : sdc_range_chk

// ==== sdc_engine.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Frame with code 0x02 twice writes a byte, half-word or word.
// - Target address is four bytes, most significant byte first.
// - Size 0x08 byte, 0x10 half, 0x20 word; others fail.
// - Data arrives MSB first; byte uses D[0], half uses D[1:0].
// - Acknowledge 12 34 34 12 in production, else 56 78 78 56.
// - Production security refuses addresses outside config windows.
// - Re-enumerate resets USB link with the frame's serial number.
// - File write brings address and count; count bytes then follow.
// - File kind 0xAA application, 0xCC signature, 0xEE config data.
// - Unknown file kind is stored but leaves the three pointers.
// - After an application file the next frame completes download.
// - Completion authenticates when needed, then starts the application.
// - Production authentication failure resumes commands with fail status.
// - Each stage but completion is command then response; only file write streams.
// - A status response sends the status word four times.
module sdc_engine (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // security level, from fuse logic on this clock
   input  wire logic        prod_sec_i,
   // received bytes from the link
   input  wire logic [7:0]  rx_byte_i,
   input  wire logic        rx_valid_i,
   output logic             rx_ready_o,
   // bytes to the link
   output logic [7:0]       tx_byte_o,
   output logic             tx_valid_o,
   input  wire logic        tx_ready_i,
   // memory write port
   output logic             mem_wr_o,
   output logic [31:0]      mem_addr_o,
   output logic [31:0]      mem_data_o,
   output logic [1:0]       mem_size_o,
   // usb re-enumeration
   output logic             reenum_o,
   output logic [31:0]      enum_serial_number_o,
   // stored file pointers
   output logic [31:0]      image_ptr_o,
   output logic [31:0]      signature_cmd_file_o,
   output logic [31:0]      config_data_file_o,
   // authentication and handoff
   output logic             auth_start_o,
   input  wire logic        auth_done_i,
   input  wire logic        auth_ok_i,
   output logic             exec_o,
   output logic [31:0]      exec_addr_o
);
   import sdc_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      sdc_state_t            state;
      logic [3:0]            idx;
      logic [FRAME_BITS-1:0] frame;
      logic [31:0]           wptr;
      logic [31:0]           rem;
      logic                  stream_ok;
      logic                  after_stream;
      logic                  app_pending;
      logic [127:0]          tx_buf;
      logic [4:0]            tx_left;
      logic                  tx_valid;
      logic                  rx_ready;
      logic [31:0]           status_word;
      logic                  mem_wr;
      logic [31:0]           mem_addr;
      logic [31:0]           mem_data;
      logic [1:0]            mem_size;
      logic                  reenum;
      logic [31:0]           serial;
      logic [31:0]           img_ptr;
      logic [31:0]           sig_ptr;
      logic [31:0]           cfg_ptr;
      logic                  auth_start;
      logic                  exec;
   } sdc_regs_t;

   sdc_regs_t r;
   sdc_regs_t next_r;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic size_ok(input logic [7:0] s);
      return (s == SIZE_BYTE) || (s == SIZE_HALF) || (s == SIZE_WORD);
   endfunction : size_ok
   function automatic logic [1:0] size_enc(input logic [7:0] s);
      unique case (s)
         SIZE_BYTE: return ACC_BYTE;
         SIZE_HALF: return ACC_HALF;
         default:   return ACC_WORD;
      endcase
   endfunction : size_enc
   logic [7:0]  cmd0;
   logic [7:0]  cmd1;
   logic [31:0] f_addr;
   logic [7:0]  f_size;
   logic [31:0] f_cnt;
   logic [31:0] f_data;
   logic [7:0]  f_kind;
   logic [31:0] span_last;
   logic        rng_ok;
   logic        addr_ok;
   logic [31:0] ack_word;
   logic        is_wmem;
   logic        is_wfile;
   logic        is_reenum;
   logic        kind_known;
   assign cmd0   = r.frame[F_CMD0 -: 8];
   assign cmd1   = r.frame[F_CMD1 -: 8];
   assign f_addr = r.frame[F_ADDR -: 32];
   assign f_size = r.frame[F_SIZE -: 8];
   assign f_cnt  = r.frame[F_CNT -: 32];
   assign f_data = r.frame[F_DATA -: 32];
   assign f_kind = r.frame[F_KIND -: 8];
   assign is_wmem    = (cmd0 == CMD_WRITE_MEM) && (cmd1 == CMD_WRITE_MEM);
   assign is_wfile   = (cmd0 == CMD_WRITE_FILE) && (cmd1 == CMD_WRITE_FILE);
   assign is_reenum  = (cmd0 == CMD_REENUM) && (cmd1 == CMD_REENUM);
   assign kind_known = (f_kind == KIND_APP) || (f_kind == KIND_SIG)
                       || (f_kind == KIND_CFG);
   assign ack_word   = prod_sec_i ? ACK_PROD : ACK_OPEN;
   // last byte touched by the pending write
   always_comb begin
      if (is_wfile) begin
         span_last = (f_cnt == 32'h0) ? f_addr : f_addr + f_cnt - 32'h1;
      end else begin
         unique case (f_size)
            SIZE_HALF: span_last = f_addr + 32'h1;
            SIZE_WORD: span_last = f_addr + 32'h3;
            default:   span_last = f_addr;
         endcase
      end
   end

   sdc_range_chk #(
      .NR       (N_RANGE)
   ) u_range (
      .first_i  (f_addr),
      .last_i   (span_last),
      .ok_o     (rng_ok)
   );
   assign addr_ok = !prod_sec_i || rng_ok;
   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r            = r;
      next_r.mem_wr     = 1'b0;
      next_r.reenum     = 1'b0;
      next_r.auth_start = 1'b0;
      next_r.exec       = 1'b0;
      unique case (r.state)
         SDC_RECV: begin
            if (rx_valid_i && r.rx_ready) begin
               next_r.frame = {r.frame[FRAME_BITS-9:0], rx_byte_i};
               next_r.idx   = r.idx + 4'h1;
               if (r.idx == LAST_IDX) begin
                  next_r.state = SDC_EXEC;
               end
            end
         end
         SDC_EXEC: begin
            next_r.state = SDC_RECV;
            if (r.app_pending) begin
               next_r.app_pending = 1'b0;
               if (prod_sec_i) begin
                  next_r.auth_start = 1'b1;
                  next_r.state      = SDC_AUTH;
               end else begin
                  next_r.exec  = 1'b1;
                  next_r.state = SDC_RUN;
               end
            end else if (is_wmem) begin
               next_r.tx_buf  = {ack_word, WR_DONE, 64'h0};
               next_r.tx_left = TX_WORD;
               next_r.state   = SDC_RESP;
               if (size_ok(f_size) && addr_ok) begin
                  next_r.tx_left  = TX_TWO_WORDS;
                  next_r.mem_wr   = 1'b1;
                  next_r.mem_addr = f_addr;
                  next_r.mem_size = size_enc(f_size);
                  unique case (f_size)
                     SIZE_BYTE: next_r.mem_data = {24'h0, f_data[7:0]};
                     SIZE_HALF: next_r.mem_data = {16'h0, f_data[15:0]};
                     default:   next_r.mem_data = f_data;
                  endcase
               end
            end else if (is_reenum) begin
               next_r.reenum  = 1'b1;
               next_r.serial  = f_addr;
               next_r.tx_buf  = {4{r.status_word}};
               next_r.tx_left = TX_FOUR_WORDS;
               next_r.state   = SDC_RESP;
            end else if (is_wfile) begin
               next_r.tx_buf       = {ack_word, 96'h0};
               next_r.tx_left      = TX_WORD;
               next_r.state        = SDC_RESP;
               next_r.wptr         = f_addr;
               next_r.rem          = f_cnt;
               next_r.stream_ok    = addr_ok;
               next_r.after_stream = (f_cnt != 32'h0);
               if (addr_ok && kind_known) begin
                  unique case (f_kind)
                     KIND_APP: next_r.img_ptr = f_addr;
                     KIND_SIG: next_r.sig_ptr = f_addr;
                     default:  next_r.cfg_ptr = f_addr;
                  endcase
                  next_r.app_pending = (f_kind == KIND_APP);
               end
            end
         end
         SDC_RESP: begin
            if (tx_ready_i && r.tx_valid) begin
               next_r.tx_buf  = {r.tx_buf[119:0], 8'h0};
               next_r.tx_left = r.tx_left - 5'h1;
               if (r.tx_left == 5'h1) begin
                  next_r.state        = r.after_stream ? SDC_STREAM
                                                       : SDC_RECV;
                  next_r.after_stream = 1'b0;
               end
            end
         end
         SDC_STREAM: begin
            if (rx_valid_i && r.rx_ready) begin
               next_r.mem_wr   = r.stream_ok;
               next_r.mem_addr = r.wptr;
               next_r.mem_data = {24'h0, rx_byte_i};
               next_r.mem_size = ACC_BYTE;
               next_r.wptr     = r.wptr + 32'h1;
               next_r.rem      = r.rem - 32'h1;
               if (r.rem == 32'h1) begin
                  next_r.state = SDC_RECV;
               end
            end
         end
         SDC_AUTH: begin
            if (auth_done_i) begin
               if (auth_ok_i) begin
                  next_r.exec  = 1'b1;
                  next_r.state = SDC_RUN;
               end else begin
                  next_r.status_word = ST_AUTH_FAIL;
                  next_r.state       = SDC_RECV;
               end
            end
         end
         SDC_RUN: begin
            next_r.state = SDC_RUN;
         end
      endcase
      next_r.rx_ready = (next_r.state == SDC_RECV)
                        || (next_r.state == SDC_STREAM);
      next_r.tx_valid = (next_r.state == SDC_RESP);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         r             <= '0;
         r.status_word <= ST_OK;
         r.rx_ready    <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rx_ready_o           = r.rx_ready;
   assign tx_byte_o            = r.tx_buf[127:120];
   assign tx_valid_o           = r.tx_valid;
   assign mem_wr_o             = r.mem_wr;
   assign mem_addr_o           = r.mem_addr;
   assign mem_data_o           = r.mem_data;
   assign mem_size_o           = r.mem_size;
   assign reenum_o             = r.reenum;
   assign enum_serial_number_o = r.serial;
   assign image_ptr_o          = r.img_ptr;
   assign signature_cmd_file_o = r.sig_ptr;
   assign config_data_file_o   = r.cfg_ptr;
   assign auth_start_o         = r.auth_start;
   assign exec_o               = r.exec;
   assign exec_addr_o          = r.img_ptr;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_wmem_exec;
      r.state == SDC_EXEC && !r.app_pending && is_wmem;
   endsequence
   sequence s_ack_first;
      tx_valid_o && tx_byte_o == $past(ack_word[31:24]);
   endsequence
   bad_size_a: assert property (s_wmem_exec and !size_ok(f_size)
      |=> !mem_wr_o && r.tx_left == TX_WORD)
      else $error("bad size produced a write");
   byte_mask_a: assert property (mem_wr_o && mem_size_o == ACC_BYTE
      |-> mem_data_o[31:8] == 24'h0)
      else $error("byte write carries upper data");
   ack_word_a: assert property (s_wmem_exec |=> s_ack_first)
      else $error("wrong acknowledge byte");
   done_word_a: assert property (s_wmem_exec and size_ok(f_size)
      and addr_ok |=> mem_wr_o && r.tx_left == TX_TWO_WORDS)
      else $error("good write lacks completion word");
   range_block_a: assert property (s_wmem_exec and prod_sec_i
      and !rng_ok |=> !mem_wr_o)
      else $error("out of range write under production");
   status_four_a: assert property (reenum_o
      |-> r.tx_left == TX_FOUR_WORDS
          && r.tx_buf[127:96] == r.tx_buf[31:0])
      else $error("status not sent four times");
   stream_addr_a: assert property (r.state == SDC_STREAM
      && rx_valid_i && rx_ready_o && r.stream_ok
      |=> mem_wr_o && mem_addr_o == $past(r.wptr))
      else $error("stream byte not stored in order");
   ptr_keep_a: assert property (r.state == SDC_EXEC
      && !r.app_pending && is_wfile && !kind_known
      |=> $stable(image_ptr_o) && $stable(signature_cmd_file_o)
          && $stable(config_data_file_o))
      else $error("unknown kind moved a pointer");
   complete_a: assert property (r.state == SDC_EXEC
      && r.app_pending |=> (prod_sec_i ? auth_start_o : exec_o))
      else $error("completion frame not honoured");
   auth_fail_a: assert property (r.state == SDC_AUTH && auth_done_i
      && !auth_ok_i |=> r.state == SDC_RECV && !exec_o
      ##0 r.status_word == ST_AUTH_FAIL)
      else $error("auth failure not recorded");

endmodule : sdc_engine

// ==== sdc_host_model.sv ====
`timescale 1ns/100ps
module sdc_host_model (
   // clock
   input  wire logic       sys_clk_i,
   // bytes towards the device
   output logic [7:0]      rx_byte_o,
   output logic            rx_valid_o,
   input  wire logic       rx_ready_i,
   // bytes from the device
   input  wire logic [7:0] tx_byte_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o
);
   logic [7:0] got_q[$];
   bit         slow;

   initial begin
      rx_byte_o  = 8'h00;
      rx_valid_o = 1'b0;
      tx_ready_o = 1'b1;
      slow       = 1'b0;
   end

   // ----------------------------------------------------------------
   // response collection, stalling every other cycle when slow
   // ----------------------------------------------------------------
   always @(negedge sys_clk_i) begin
      tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
   end

   always @(posedge sys_clk_i) begin
      if (tx_valid_i === 1'b1 && tx_ready_o) begin
         got_q.push_back(tx_byte_i);
      end
   end

   // ----------------------------------------------------------------
   // frames and streams, each byte held until taken
   // ----------------------------------------------------------------
   task automatic send(input logic [7:0] q[$], output int taken);
      int n;
      taken = 0;
      n     = 0;
      while (taken < q.size() && n < 64 * q.size() + 64) begin
         @(negedge sys_clk_i);
         rx_byte_o  = q[taken];
         rx_valid_o = 1'b1;
         @(posedge sys_clk_i);
         if (rx_ready_i === 1'b1) taken++;
         n++;
      end
      @(negedge sys_clk_i);
      rx_valid_o = 1'b0;
      // released line shows no stale byte
      rx_byte_o  = ~rx_byte_o;
   endtask : send
endmodule : sdc_host_model

// ==== tb_serial_download_cmd_engine.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) \
   begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_serial_download_cmd_engine;
   import sdc_pkg::*;
   logic        sys_clk_i, rst_i, prod_sec_i, rx_valid_i, rx_ready_o;
   logic        tx_valid_o, tx_ready_i, mem_wr_o, reenum_o, auth_start_o;
   logic        auth_done_i, auth_ok_i, exec_o;
   logic [7:0]  rx_byte_i, tx_byte_o;
   logic [1:0]  mem_size_o;
   logic [31:0] mem_addr_o, mem_data_o, enum_serial_number_o, exec_addr_o;
   logic [31:0] image_ptr_o, signature_cmd_file_o, config_data_file_o;
   logic [31:0] seed, m_img, m_sig, m_cfg, a;
   logic [65:0] wr_q[$], ew_q[$];
   logic [7:0]  exp_q[$];
   int          checked, miscompares, n_reenum, n_auth, n_exec;
   bit          auth_pass;

   sdc_engine u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .prod_sec_i(prod_sec_i), .rx_byte_i(rx_byte_i),
      .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o),
      .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o),
      .tx_ready_i(tx_ready_i), .mem_wr_o(mem_wr_o),
      .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
      .mem_size_o(mem_size_o), .reenum_o(reenum_o),
      .enum_serial_number_o(enum_serial_number_o),
      .image_ptr_o(image_ptr_o),
      .signature_cmd_file_o(signature_cmd_file_o),
      .config_data_file_o(config_data_file_o),
      .auth_start_o(auth_start_o), .auth_done_i(auth_done_i),
      .auth_ok_i(auth_ok_i), .exec_o(exec_o), .exec_addr_o(exec_addr_o));

   sdc_host_model u_host (.sys_clk_i(sys_clk_i), .rx_byte_o(rx_byte_i),
      .rx_valid_o(rx_valid_i), .rx_ready_i(rx_ready_o),
      .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
      .tx_ready_o(tx_ready_i));

   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end

   // ----------------------------------------------------------------
   // monitors and authentication responder
   // ----------------------------------------------------------------
   always @(posedge sys_clk_i) begin
      if (mem_wr_o === 1'b1) wr_q.push_back({mem_size_o, mem_addr_o, mem_data_o});
      if (reenum_o === 1'b1) n_reenum++;
      if (auth_start_o === 1'b1) n_auth++;
      if (exec_o === 1'b1) n_exec++;
   end

   initial forever begin
      @(posedge sys_clk_i);
      if (auth_start_o === 1'b1) begin
         repeat (3) @(negedge sys_clk_i);
         auth_ok_i   = auth_pass;
         auth_done_i = 1'b1;
         @(negedge sys_clk_i);
         auth_done_i = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // reference model helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   function automatic logic [31:0] ack();
      return prod_sec_i ? 32'h12343412 : 32'h56787856;
   endfunction : ack

   task automatic put(input logic [31:0] w, input int reps);
      repeat (reps) for (int i = 3; i >= 0; i--) exp_q.push_back(w[8*i+:8]);
   endtask : put

   task automatic give_verdict();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   task automatic settle();
      repeat (4) @(negedge sys_clk_i);
      `CHK("resp_len", exp_q.size(), u_host.got_q.size())
      for (int i = 0; i < exp_q.size() && i < u_host.got_q.size(); i++)
         `CHK("resp_byte", exp_q[i], u_host.got_q[i])
      `CHK("wr_cnt", ew_q.size(), wr_q.size())
      for (int i = 0; i < ew_q.size() && i < wr_q.size(); i++)
         `CHK("wr", ew_q[i], wr_q[i])
      exp_q        = {};
      ew_q         = {};
      wr_q         = {};
      u_host.got_q = {};
   endtask : settle

   task automatic run(input logic [127:0] f, input bit to_exec);
      logic [7:0] q[$];
      int         t;
      int         n;
      int         e0;
      for (int i = 15; i >= 0; i--) q.push_back(f[8*i+:8]);
      e0 = n_exec;
      u_host.send(q, t);
      n = 0;
      repeat (2) @(negedge sys_clk_i);
      while (n < 500 && !(to_exec ? n_exec > e0 : rx_ready_o === 1'b1 &&
             u_host.got_q.size() >= exp_q.size())) begin
         @(negedge sys_clk_i);
         n++;
      end
      if (t != 16 || n == 500) begin
         $display("[ERR] wait expected 16 seen %0d", t);
         miscompares++;
         give_verdict();
      end
      settle();
   endtask : run

   task automatic mwrite(input logic [31:0] ad, input logic [7:0] s,
                         input bit in_rng);
      logic [31:0] d;
      logic [1:0]  z;
      d = rnd();
      z = (s == 8'h08) ? ACC_BYTE : (s == 8'h10) ? ACC_HALF : ACC_WORD;
      put(ack(), 1);
      if (in_rng && (s == 8'h08 || s == 8'h10 || s == 8'h20)) begin
         put(32'h128a8a12, 1);
         ew_q.push_back({z, ad, s == 8'h08 ? d & 32'hff :
                         s == 8'h10 ? d & 32'hffff : d});
      end
      run({CMD_WRITE_MEM, CMD_WRITE_MEM, ad, s, rnd(), d, 8'h00}, 1'b0);
   endtask : mwrite

   task automatic fwrite(input logic [31:0] ad, input int cnt,
                         input logic [7:0] k, input bit ok);
      logic [7:0]  q[$];
      logic [31:0] r;
      int          t;
      put(ack(), 1);
      run({CMD_WRITE_FILE, CMD_WRITE_FILE, ad, 8'h00, 32'(cnt), rnd(), k}, 1'b0);
      for (int i = 0; i < cnt; i++) begin
         r = rnd();
         q.push_back(r[7:0]);
         if (ok) ew_q.push_back({ACC_BYTE, 32'(ad + i), 24'h0, r[7:0]});
      end
      u_host.send(q, t);
      `CHK("stream", cnt, t)
      settle();
      if (ok && k == 8'haa) m_img = ad;
      if (ok && k == 8'hcc) m_sig = ad;
      if (ok && k == 8'hee) m_cfg = ad;
      `CHK("img", m_img, image_ptr_o)
      `CHK("sig", m_sig, signature_cmd_file_o)
      `CHK("cfg", m_cfg, config_data_file_o)
   endtask : fwrite

   task automatic do_reset(input bit p);
      @(negedge sys_clk_i);
      rst_i      = 1'b1;
      prod_sec_i = p;
      repeat (4) @(negedge sys_clk_i);
      rst_i = 1'b0;
      m_img = 32'h0;
      m_sig = 32'h0;
      m_cfg = 32'h0;
      `CHK("ready_rst", 1'b1, rx_ready_o)
   endtask : do_reset

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_i       = 1'b1;
      prod_sec_i  = 1'b0;
      auth_done_i = 1'b0;
      auth_ok_i   = 1'b0;
      seed        = 32'h2865;
      do_reset(1'b0);
      u_host.slow = 1'b1;
      mwrite(rnd(), 8'h08, 1'b1);
      mwrite(rnd(), 8'h10, 1'b1);
      mwrite(rnd(), 8'h20, 1'b1);
      mwrite(rnd(), 8'h30, 1'b1);
      run({CMD_WRITE_MEM, 8'h03, rnd(), rnd(), rnd(),
           16'(rnd())}, 1'b0);
      a = rnd();
      put(32'hf0f0f0f0, 4);
      run({CMD_REENUM, CMD_REENUM, a, rnd(), rnd(), 16'(rnd())}, 1'b0);
      `CHK("serial", a, enum_serial_number_o)
      `CHK("reenum", 1, n_reenum)
      u_host.slow = 1'b0;
      fwrite(rnd(), 3, 8'hcc, 1'b1);
      fwrite(rnd(), 2, 8'hee, 1'b1);
      fwrite(rnd(), 3, 8'h55, 1'b1);
      fwrite(rnd(), 2, 8'haa, 1'b1);
      run({rnd(), rnd(), rnd(), rnd()}, 1'b1);
      `CHK("exec_addr", m_img, exec_addr_o)
      `CHK("auth", 0, n_auth)
      do_reset(1'b1);
      mwrite(32'h30000000, 8'h20, 1'b0);
      mwrite(32'h1000fffc, 8'h20, 1'b1);
      mwrite(32'h2000ffff, 8'h10, 1'b0);
      fwrite(32'h40000000, 2, 8'hee, 1'b0);
      fwrite(32'h20000100, 2, 8'haa, 1'b1);
      auth_pass = 1'b0;
      run({rnd(), rnd(), rnd(), rnd()}, 1'b0);
      `CHK("auth", 1, n_auth)
      put(32'h33333333, 4);
      run({CMD_REENUM, CMD_REENUM, rnd(), rnd(), rnd(),
           16'(rnd())}, 1'b0);
      fwrite(32'h20000200, 1, 8'haa, 1'b1);
      auth_pass = 1'b1;
      run({rnd(), rnd(), rnd(), rnd()}, 1'b1);
      `CHK("auth", 2, n_auth)
      `CHK("exec", 2, n_exec)
      `CHK("exec_addr", m_img, exec_addr_o)
      give_verdict();
   end
endmodule : tb_serial_download_cmd_engine
